// [hdl/phy_port_pkg.sv]
// constants, codes and carriers shared by the bit-granular service port
// assumes one clock domain; line timing is counted in clock cycles
package phy_port_pkg;

  localparam int CNT_W = 16;
  // cycles per bit period on the medium (two halves per symbol)
  localparam int BIT_CYCLES_DEF = 8;
  // preamble symbols sent ahead of the start delimiter
  localparam int PRE_BITS_DEF = 4;
  // bit periods of silence that close a period of activity
  localparam int QUIET_BITS_DEF = 2;
  localparam int BUF_DEPTH_DEF = 2;

  // half-symbol pairs: first half in bit 1
  localparam logic [1:0] SYM_ONE = 2'h2;
  localparam logic [1:0] SYM_ZERO = 2'h1;
  localparam logic [1:0] SYM_START = 2'h3;
  localparam logic [1:0] SYM_END = 2'h0;

  typedef enum logic [1:0] {
    ACTIVITY_START_CLASS = 2'h0,
    DATA_CLASS = 2'h1,
    ACTIVITY_END_CLASS = 2'h2
  } class_t;

  typedef enum logic [1:0] {
    STAT_OK = 2'h0,
    STAT_SEQ_ERR = 2'h1,
    STAT_UNDERRUN = 2'h2
  } status_t;

  typedef struct packed {
    logic valid;
    class_t cls;
    logic data;
  } primitive_t;

  typedef struct packed {
    logic valid;
    status_t status;
  } confirm_t;

  typedef struct packed {
    class_t cls;
    logic data;
  } unit_t;

  localparam int UNIT_W = $bits(unit_t);

endpackage

// [hdl/unit_buffer.sv]
// small register-based fifo with valid/ready on both sides
// assumes a synchronous active-high reset on the same clock
`timescale 1ns/10ps
module unit_buffer #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // fill side
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  // drain side
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // pointers wrap by overflow, so only powers of two are served
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_params
    $error("unit_buffer: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [PW:0] count_reg, count_next;
  logic push, pop;

  assign o_wr_ready = (count_reg != (PW+1)'(DEPTH));
  assign o_rd_valid = (count_reg != '0);
  assign o_rd_data = mem_reg[rd_ptr_reg];
  assign push = i_wr_valid && o_wr_ready;
  assign pop = o_rd_valid && i_rd_ready;

  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = i_wr_data;
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

endmodule // unit_buffer

// [hdl/phy_service_port.sv]
// bit-granular physical service port: request/confirm for sending,
// indications for receiving, symbol coder and decoder for the medium
// assumes the link layer logic shares I_REF_CLK and waits for confirms;
// the receive line comes from a pin and is synchronised here
`timescale 1ns/10ps
// Contract
// [R1] every service data unit is one bit
// [R2] start request sends preamble and start delimiter
// [R3] data request sends one bit, frame continuous
// [R4] end request sends end delimiter, then release line
// [R5] start indication when line activity begins
// [R6] data indication only inside correctly formed reception
// [R7] end indication after line stays quiet
// [R8] confirm carries success or local failure cause
// [R9] last confirm waits until end delimiter sent
// [R10] link layer frames start, data bits, end
// [R11] one confirm per request, means ready again
// [R12] link layer waits confirm before next request
// [R13] indications: start, data bits, then end
// [R14] two-bit class, one-cycle strobes, status on confirm
// [R15] data/end without start fails, sends nothing
module phy_service_port
  import phy_port_pkg::*;
#(
  parameter int BIT_CYCLES = phy_port_pkg::BIT_CYCLES_DEF,
  parameter int PRE_BITS = phy_port_pkg::PRE_BITS_DEF,
  parameter int QUIET_BITS = phy_port_pkg::QUIET_BITS_DEF,
  parameter int BUF_DEPTH = phy_port_pkg::BUF_DEPTH_DEF
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // link layer requests and confirms
  input wire phy_port_pkg::primitive_t I_REQ,
  output phy_port_pkg::confirm_t O_CNF,
  // link layer indications
  output phy_port_pkg::primitive_t O_IND,
  // medium
  output logic O_TX_LINE,
  output logic O_TX_EN,
  input wire logic I_RX_LINE
);
  import phy_port_pkg::*;

  localparam int HALF = BIT_CYCLES / 2;
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_C = CNT_W'(HALF);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF - 1);
  localparam logic [CNT_W-1:0] CENTER = CNT_W'(HALF / 2);
  localparam logic [CNT_W-1:0] PRE_LAST = CNT_W'(PRE_BITS - 1);
  localparam logic [CNT_W-1:0] QUIET_LAST = CNT_W'(QUIET_BITS * BIT_CYCLES - 1);

  if (BIT_CYCLES < 4 || (BIT_CYCLES % 2) != 0 || PRE_BITS < 1 || QUIET_BITS < 2 ||
      QUIET_BITS * BIT_CYCLES >= (1 << (CNT_W - 1))) begin : g_bad_params
    $error("phy_service_port: unsupported timing parameters");
  end

  // ---------------- request front end ----------------
  primitive_t pend_reg, pend_next;
  confirm_t cnf_reg, cnf_next;
  logic in_frame_reg, in_frame_next;
  logic fail_reg, fail_next;
  logic wait_end_reg, wait_end_next;
  logic buf_wr_valid, buf_wr_ready, buf_rd_valid, buf_rd_ready;
  unit_t buf_wr_data, buf_rd_data;
  logic end_done, underrun, tx_busy;

  assign O_CNF = cnf_reg;

  always_comb begin
    pend_next = pend_reg;
    cnf_next = '0;
    in_frame_next = in_frame_reg;
    fail_next = fail_reg;
    wait_end_next = wait_end_reg;
    buf_wr_valid = 1'b0;
    buf_wr_data = '{cls: pend_reg.cls, data: pend_reg.data}; // [R1]
    if (I_REQ.valid) begin
      pend_next = I_REQ; // [R12]
    end
    if (wait_end_reg && end_done) begin
      cnf_next = '{valid: 1'b1, status: STAT_OK}; // [R9]
      wait_end_next = 1'b0;
    end else if (pend_reg.valid && !wait_end_reg) begin
      case (pend_reg.cls)
        ACTIVITY_START_CLASS: begin
          if (in_frame_reg) begin
            cnf_next = '{valid: 1'b1, status: STAT_SEQ_ERR}; // [R8]
            pend_next.valid = 1'b0;
          end else if (buf_wr_ready) begin
            buf_wr_valid = 1'b1; // [R2]
            cnf_next = '{valid: 1'b1, status: STAT_OK}; // [R11]
            in_frame_next = 1'b1;
            fail_next = 1'b0;
            pend_next.valid = 1'b0;
          end
        end
        DATA_CLASS: begin
          if (!in_frame_reg) begin
            cnf_next = '{valid: 1'b1, status: STAT_SEQ_ERR}; // [R15]
            pend_next.valid = 1'b0;
          end else if (fail_reg) begin
            cnf_next = '{valid: 1'b1, status: STAT_UNDERRUN}; // [R8]
            pend_next.valid = 1'b0;
          end else if (buf_wr_ready) begin
            buf_wr_valid = 1'b1; // [R3]
            cnf_next = '{valid: 1'b1, status: STAT_OK}; // [R11]
            pend_next.valid = 1'b0;
          end
        end
        ACTIVITY_END_CLASS: begin
          if (!in_frame_reg) begin
            cnf_next = '{valid: 1'b1, status: STAT_SEQ_ERR}; // [R15]
            pend_next.valid = 1'b0;
          end else if (fail_reg) begin
            // aborted frame: answer only once the line is released
            if (!tx_busy) begin
              cnf_next = '{valid: 1'b1, status: STAT_UNDERRUN}; // [R9]
              in_frame_next = 1'b0;
              pend_next.valid = 1'b0;
            end
          end else if (buf_wr_ready) begin
            buf_wr_valid = 1'b1; // [R4]
            wait_end_next = 1'b1; // [R9]
            in_frame_next = 1'b0;
            pend_next.valid = 1'b0;
          end
        end
        default: begin
          cnf_next = '{valid: 1'b1, status: STAT_SEQ_ERR}; // [R14]
          pend_next.valid = 1'b0;
        end
      endcase
    end
    // set wins over the clear by a new start
    if (underrun) begin
      fail_next = 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pend_reg <= '0;
      cnf_reg <= '0;
      in_frame_reg <= 1'b0;
      fail_reg <= 1'b0;
      wait_end_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      cnf_reg <= cnf_next;
      in_frame_reg <= in_frame_next;
      fail_reg <= fail_next;
      wait_end_reg <= wait_end_next;
    end
  end

  // start and data confirms are given on entry, so the buffer hides the link layer's
  // turnaround and keeps the frame continuous
  unit_buffer #(
    .WIDTH(UNIT_W),
    .DEPTH(BUF_DEPTH)
  ) u_buffer (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_wr_valid(buf_wr_valid),
    .o_wr_ready(buf_wr_ready),
    .i_wr_data(buf_wr_data),
    .o_rd_valid(buf_rd_valid),
    .i_rd_ready(buf_rd_ready),
    .o_rd_data(buf_rd_data)
  );

  // ---------------- transmit symbol engine ----------------
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_PRE = 4'h2,
    TX_FRAME = 4'h4,
    TX_TAIL = 4'h8
  } tx_state_t;

  tx_state_t tx_state_reg, tx_state_next;
  logic [1:0] sym_reg, sym_next;
  logic [CNT_W-1:0] cyc_reg, cyc_next, pre_reg, pre_next;
  logic line_reg, line_next, en_reg, en_next;
  logic sym_end;

  assign sym_end = (cyc_reg == BIT_LAST);
  assign tx_busy = (tx_state_reg != TX_IDLE) || buf_rd_valid;
  assign O_TX_LINE = line_reg;
  assign O_TX_EN = en_reg;

  always_comb begin
    tx_state_next = tx_state_reg;
    sym_next = sym_reg;
    pre_next = pre_reg;
    cyc_next = sym_end ? '0 : cyc_reg + 1'b1;
    buf_rd_ready = 1'b0;
    end_done = 1'b0;
    underrun = 1'b0;
    case (tx_state_reg)
      TX_IDLE: begin
        cyc_next = '0;
        if (buf_rd_valid) begin
          // stray units outside a frame are dropped
          buf_rd_ready = 1'b1;
          if (buf_rd_data.cls == ACTIVITY_START_CLASS) begin
            tx_state_next = TX_PRE; // [R2]
            sym_next = SYM_ONE;
            pre_next = PRE_LAST;
          end
        end
      end
      TX_PRE: begin
        if (sym_end) begin
          if (pre_reg == '0) begin
            tx_state_next = TX_FRAME; // [R2]
            sym_next = SYM_START;
          end else begin
            pre_next = pre_reg - 1'b1;
          end
        end
      end
      TX_FRAME: begin
        if (sym_end) begin
          buf_rd_ready = 1'b1;
          if (!buf_rd_valid) begin
            // starved: close the frame rather than send a malformed one
            tx_state_next = TX_TAIL;
            sym_next = SYM_END;
            underrun = 1'b1;
          end else if (buf_rd_data.cls == DATA_CLASS) begin
            sym_next = buf_rd_data.data ? SYM_ONE : SYM_ZERO; // [R3]
          end else begin
            tx_state_next = TX_TAIL; // [R4]
            sym_next = SYM_END;
          end
        end
      end
      TX_TAIL: begin
        if (sym_end) begin
          tx_state_next = TX_IDLE; // [R4]
          end_done = 1'b1; // [R9]
        end
      end
      default: begin
        tx_state_next = TX_IDLE;
      end
    endcase
    en_next = (tx_state_next != TX_IDLE);
    line_next = en_next && ((cyc_next < HALF_C) ? sym_next[1] : sym_next[0]);
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      tx_state_reg <= TX_IDLE;
      sym_reg <= SYM_END;
      cyc_reg <= '0;
      pre_reg <= '0;
      line_reg <= 1'b0;
      en_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      sym_reg <= sym_next;
      cyc_reg <= cyc_next;
      pre_reg <= pre_next;
      line_reg <= line_next;
      en_reg <= en_next;
    end
  end

  // ---------------- receive decoder ----------------
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_HUNT = 4'h2,
    RX_DATA = 4'h4,
    RX_QUIET = 4'h8
  } rx_state_t;

  logic [2:0] sync_reg, sync_next;
  logic rx_reg, rx_next;
  rx_state_t rx_state_reg, rx_state_next;
  logic [CNT_W-1:0] rcnt_reg, rcnt_next;
  logic sel_reg, sel_next, first_reg, first_next;
  primitive_t ind_reg, ind_next;

  assign O_IND = ind_reg;

  // no phase tracking: both ends are assumed to run from matched clocks
  always_comb begin
    sync_next = {sync_reg[1:0], I_RX_LINE};
    rx_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : rx_reg;
    rx_state_next = rx_state_reg;
    rcnt_next = rcnt_reg;
    sel_next = sel_reg;
    first_next = first_reg;
    ind_next = '0;
    case (rx_state_reg)
      RX_IDLE: begin
        if (rx_reg) begin
          ind_next = '{valid: 1'b1, cls: ACTIVITY_START_CLASS, data: 1'b0}; // [R5]
          rx_state_next = RX_HUNT;
          rcnt_next = CENTER;
          sel_next = 1'b0;
        end
      end
      RX_HUNT, RX_DATA: begin
        if (rcnt_reg != '0) begin
          rcnt_next = rcnt_reg - 1'b1;
        end else begin
          rcnt_next = HALF_LAST;
          sel_next = !sel_reg;
          if (!sel_reg) begin
            first_next = rx_reg;
          end else if (rx_state_reg == RX_HUNT) begin
            if ({first_reg, rx_reg} == SYM_START) begin
              rx_state_next = RX_DATA;
            end else if ({first_reg, rx_reg} != SYM_ONE) begin
              rx_state_next = RX_QUIET;
              rcnt_next = '0;
            end
          end else if ({first_reg, rx_reg} == SYM_ONE || {first_reg, rx_reg} == SYM_ZERO) begin
            ind_next = '{valid: 1'b1, cls: DATA_CLASS, data: first_reg}; // [R6]
          end else begin
            // end delimiter or violation: no more data till next activity
            rx_state_next = RX_QUIET; // [R6]
            rcnt_next = '0;
          end
        end
      end
      RX_QUIET: begin
        if (rx_reg) begin
          rcnt_next = '0;
        end else if (rcnt_reg == QUIET_LAST) begin
          ind_next = '{valid: 1'b1, cls: ACTIVITY_END_CLASS, data: 1'b0}; // [R7]
          rx_state_next = RX_IDLE; // [R13]
        end else begin
          rcnt_next = rcnt_reg + 1'b1;
        end
      end
      default: begin
        rx_state_next = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      sync_reg <= '0;
      rx_reg <= 1'b0;
      rx_state_reg <= RX_IDLE;
      rcnt_reg <= '0;
      sel_reg <= 1'b0;
      first_reg <= 1'b0;
      ind_reg <= '0;
    end else begin
      sync_reg <= sync_next;
      rx_reg <= rx_next;
      rx_state_reg <= rx_state_next;
      rcnt_reg <= rcnt_next;
      sel_reg <= sel_next;
      first_reg <= first_next;
      ind_reg <= ind_next;
    end
  end

endmodule // phy_service_port

// [bench/port_monitor.sv]
// checker for the service port: strobes, confirm timing, indication order
// assumes default parameters and the single reference clock
`timescale 1ns/10ps
module port_monitor
  import phy_port_pkg::*;
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // service side
  input wire phy_port_pkg::primitive_t I_REQ,
  input wire phy_port_pkg::confirm_t O_CNF,
  input wire phy_port_pkg::primitive_t O_IND,
  // medium
  input wire logic O_TX_LINE,
  input wire logic O_TX_EN,
  input wire logic I_RX_LINE
);
  logic pend_reg, pend_next, open_reg, open_next;
  class_t last_reg, last_next;

  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  always_comb begin
    pend_next = (pend_reg && !O_CNF.valid) || I_REQ.valid;
    last_next = I_REQ.valid ? I_REQ.cls : last_reg;
    open_next = open_reg;
    if (O_IND.valid && O_IND.cls == ACTIVITY_START_CLASS) begin
      open_next = 1'b1;
    end
    if (O_IND.valid && O_IND.cls == ACTIVITY_END_CLASS) begin
      open_next = 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    pend_reg <= I_RST ? 1'b0 : pend_next;
    last_reg <= I_RST ? ACTIVITY_START_CLASS : last_next;
    open_reg <= I_RST ? 1'b0 : open_next;
  end

  sequence cnf_after2;
    !O_CNF.valid ##1 O_CNF.valid;
  endsequence
  // preamble symbol at eight cycles a bit: high half, low half
  sequence pre_sym;
    O_TX_LINE [*4] ##1 !O_TX_LINE [*4];
  endsequence

  a_cnf_one_cycle: assert property (O_CNF.valid |=> !O_CNF.valid)
    else $error("confirm strobe longer than one cycle");
  a_ind_one_cycle: assert property (O_IND.valid |=> !O_IND.valid)
    else $error("indication strobe longer than one cycle");
  a_cnf_has_req: assert property (O_CNF.valid |-> pend_reg)
    else $error("confirm without an open request");
  a_start_cnf_time: assert property (I_REQ.valid && I_REQ.cls == ACTIVITY_START_CLASS
    && !O_TX_EN |=> cnf_after2) else $error("start confirm not two cycles after request");
  a_end_cnf_released: assert property (O_CNF.valid && O_CNF.status == STAT_OK
    && last_reg == ACTIVITY_END_CLASS |-> !O_TX_EN) else $error("end confirm while driving");
  a_tx_idle_low: assert property (!O_TX_EN |-> !O_TX_LINE)
    else $error("line high while not driven");
  a_preamble_shape: assert property ($rose(O_TX_EN) |-> pre_sym ##1 pre_sym)
    else $error("frame does not open with preamble");
  a_ind_data_inside: assert property (O_IND.valid && O_IND.cls == DATA_CLASS |-> open_reg)
    else $error("data indication outside activity");
  a_ind_start_once: assert property (O_IND.valid && O_IND.cls == ACTIVITY_START_CLASS
    |-> !open_reg) else $error("second start indication");
  a_ind_cls_legal: assert property (O_IND.valid |-> O_IND.cls != 2'h3)
    else $error("indication with unused class");
endmodule // port_monitor

bind phy_service_port port_monitor i_mon (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_REQ(I_REQ),
  .O_CNF(O_CNF), .O_IND(O_IND), .O_TX_LINE(O_TX_LINE), .O_TX_EN(O_TX_EN),
  .I_RX_LINE(I_RX_LINE));

// [bench/link_model.sv]
// link layer model: one request at a time, waits confirm, logs indications
// assumes requests are launched one step after the rising edge
`timescale 1ns/10ps
module link_model
  import phy_port_pkg::*;
(
  input wire logic i_clk,
  output phy_port_pkg::primitive_t o_req,
  input wire phy_port_pkg::confirm_t i_cnf,
  input wire phy_port_pkg::primitive_t i_ind
);
  unit_t rx_q[$];

  initial o_req = '0;

  always @(posedge i_clk) begin
    if (i_ind.valid === 1'b1) begin
      rx_q.push_back({i_ind.cls, i_ind.data});
    end
  end

  // one bit per request, next one only after its confirm or after 3000 cycles without one
  task automatic request(input class_t c, input logic d, input int gap, output logic [1:0] st);
    int n;
    st = 2'bxx;
    repeat (gap) @(posedge i_clk);
    #1 o_req = '{valid: 1'b1, cls: c, data: d};
    @(posedge i_clk);
    #1 o_req.valid = 1'b0;
    for (n = 0; n < 3000; n++) begin
      @(posedge i_clk);
      if (i_cnf.valid === 1'b1) begin
        st = i_cnf.status;
        break;
      end
    end
  endtask
endmodule // link_model

// [bench/testbench.sv]
// self-checking bench for the service port, transmit looped to receive
// assumes default line timing parameters
`timescale 1ns/10ps
module testbench;
  import phy_port_pkg::*;
  typedef struct {class_t c; logic d; int gap; status_t st;} row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx_line;
  primitive_t req, ind;
  confirm_t cnf;
  logic tx_line, tx_en;
  logic [1:0] st;
  int errors = 0;
  int comparisons = 0;
  row_t rows[11] = '{
    '{ACTIVITY_START_CLASS, 1'b0, 0, STAT_OK}, '{DATA_CLASS, 1'b1, 0, STAT_OK},
    '{DATA_CLASS, 1'b0, 0, STAT_OK}, '{DATA_CLASS, 1'b1, 0, STAT_OK},
    '{ACTIVITY_END_CLASS, 1'b0, 0, STAT_OK}, '{ACTIVITY_END_CLASS, 1'b0, 0, STAT_SEQ_ERR},
    '{DATA_CLASS, 1'b1, 0, STAT_SEQ_ERR}, '{class_t'(2'h3), 1'b0, 0, STAT_SEQ_ERR},
    '{ACTIVITY_START_CLASS, 1'b0, 30, STAT_OK},
    '{ACTIVITY_START_CLASS, 1'b0, 0, STAT_SEQ_ERR}, '{ACTIVITY_END_CLASS, 1'b0, 0, STAT_OK}};
  unit_t exp_q[$] = '{{ACTIVITY_START_CLASS, 1'b0}, {DATA_CLASS, 1'b1}, {DATA_CLASS, 1'b0},
    {DATA_CLASS, 1'b1}, {ACTIVITY_END_CLASS, 1'b0}, {ACTIVITY_START_CLASS, 1'b0},
    {ACTIVITY_END_CLASS, 1'b0}};

  always #4 clk = ~clk;
  // released line is biased low, so idle never looks like activity
  assign rx_line = tx_en ? tx_line : 1'b0;

  phy_service_port i_dut (.I_REF_CLK(clk), .I_RST(rst), .I_REQ(req), .O_CNF(cnf),
    .O_IND(ind), .O_TX_LINE(tx_line), .O_TX_EN(tx_en), .I_RX_LINE(rx_line));
  link_model i_dll (.i_clk(clk), .o_req(req), .i_cnf(cnf), .i_ind(ind));

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic req_chk(input class_t c, input logic d, input int gap, input status_t s);
    i_dll.request(c, d, gap, st);
    check({2'b00, st}, {2'b00, s});
  endtask

  initial begin
    // a full stored frame plus the end symbol stays well inside this span
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    foreach (rows[i]) begin
      req_chk(rows[i].c, rows[i].d, rows[i].gap, rows[i].st);
      if (rows[i].c == ACTIVITY_END_CLASS && rows[i].st == STAT_OK) begin
        check({3'b000, tx_en}, 4'h0);
      end
      if (i == 7) begin
        check({3'b000, tx_en}, 4'h0);
      end
    end
    repeat (60) @(posedge clk);
    check(4'(i_dll.rx_q.size()), 4'(exp_q.size()));
    foreach (exp_q[i]) begin
      if (i < i_dll.rx_q.size()) begin
        check({1'b0, i_dll.rx_q[i]}, {1'b0, exp_q[i]});
      end
    end
    // slow link layer: frame starves and closes early
    req_chk(ACTIVITY_START_CLASS, 1'b0, 0, STAT_OK);
    req_chk(DATA_CLASS, 1'b1, 0, STAT_OK);
    req_chk(DATA_CLASS, 1'b0, 200, STAT_UNDERRUN);
    req_chk(ACTIVITY_END_CLASS, 1'b0, 0, STAT_UNDERRUN);
    req_chk(ACTIVITY_START_CLASS, 1'b0, 40, STAT_OK);
    req_chk(ACTIVITY_END_CLASS, 1'b0, 0, STAT_OK);
    // reset in mid-frame drops the line and closes the frame
    req_chk(ACTIVITY_START_CLASS, 1'b0, 40, STAT_OK);
    req_chk(DATA_CLASS, 1'b1, 0, STAT_OK);
    repeat (10) @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    check({1'b0, tx_en, cnf.valid, ind.valid}, 4'h0);
    req_chk(DATA_CLASS, 1'b1, 0, STAT_SEQ_ERR);
    repeat (40) @(posedge clk);
    test_done();
  end
endmodule // testbench
